// ### l2c_pkg.sv
package l2c_pkg;

  // ==========================================
  // Line and array geometry
  localparam int L2C_LINE_BYTES = 32;
  localparam int L2C_OFF_W = 5;
  localparam int L2C_WAYS = 4;
  localparam int L2C_WAY_W = 2;
  localparam int L2C_LINE_W = 256;
  localparam int L2C_ADDR_W = 40;
  localparam int L2C_KB = 512;

  // ==========================================
  // Tag record field positions
  localparam int L2C_TR_VALID = 0;
  localparam int L2C_TR_DIRTY = 1;
  localparam int L2C_TR_PEND = 2;
  localparam int L2C_TR_TAG = 3;

  // ==========================================
  // Reset values and fixed codes
  localparam logic [15:0] L2C_LFSR_SEED = 16'hACE1;
  localparam logic [15:0] L2C_LFSR_TAPS = 16'hB400;
  // Two code bits flipped to poison a line
  localparam logic [1:0] L2C_POISON = 2'h3;

  // ==========================================
  // Helpers for sizing
  // Hamming check bits needed for dw data bits
  function automatic int l2c_pbits(input int dw);
    int p;
    p = 1;
    while ((1 << p) < dw + p + 1) p++;
    return p;
  endfunction

  // Ceiling log2
  function automatic int l2c_log2(input int v);
    int n;
    n = 0;
    while ((1 << n) < v) n++;
    return n;
  endfunction

endpackage

// ### l2c_cache.sv
// Summary of operation
// - 32-byte lines, four ways, 128/256/512 KB
// - Only whole cache lines move
// - Victim way chosen at random
// - One access per cycle, never stalls
// - Single-bit tag/data errors corrected in flight
// - Hit on single error starts cleanup; preemptible
// - Bad tag: junk data plus tag error
// - Bad data: data returned plus data error
// - Capture tag of latest ECC error
// - Poisoned incoming data stored uncorrectable
// - Management invalidates line and clears ECC
// - Not L1 cacheable bypasses lookup; its write data still lands on a hit
// - Look up every L1 cacheable request
// - Allocate flag allocates on miss only
// - Write miss reserves line, takes data later
// - Read miss reserves line, snoops fill
// - Hits served regardless of allocate flag
// - All requesting agents treated alike
// - Index is bits [14:5]/[15:5]/[16:5]
`timescale 1ns/100ps

// ==========================================
// SEC-DED Hamming coder, one width per use
module l2c_secded
  import l2c_pkg::*;
#(
  parameter int DW = 256,
  parameter int CW = DW + l2c_pbits(DW) + 1
)(
  // Encoder
  input wire logic [DW-1:0] enc_data,
  output logic [CW-1:0] enc_code,
  // Decoder
  input wire logic [CW-1:0] dec_code,
  output logic [DW-1:0] dec_data,
  output logic [CW-1:0] dec_fix,
  output logic dec_sbe,
  output logic dec_dbe
);

  localparam int PB = CW - DW - 1;

  // Check bits; data bits sit on non-power-of-two positions
  function automatic logic [PB-1:0] chk_of(input logic [DW-1:0] d);
    logic [PB-1:0] c;
    int p;
    c = '0;
    p = 3;
    for (int i = 0; i < DW; i++)
    begin
      if (d[i]) c = c ^ PB'(p);
      p++;
      if ((p & (p - 1)) == 0) p++;
    end
    return c;
  endfunction

  // Flip the data bit the syndrome points at
  function automatic logic [DW-1:0] fix_of(input logic [DW-1:0] d,
                                           input logic [PB-1:0] s);
    logic [DW-1:0] r;
    int p;
    r = d;
    p = 3;
    for (int i = 0; i < DW; i++)
    begin
      if (PB'(p) == s) r[i] = ~d[i];
      p++;
      if ((p & (p - 1)) == 0) p++;
    end
    return r;
  endfunction

  wire [PB-1:0] enc_chk = chk_of(enc_data);
  wire [DW-1:0] raw = dec_code[DW-1:0];
  wire [PB-1:0] syn = chk_of(raw) ^ dec_code[DW +: PB];
  // Odd overall parity means exactly one bit flipped
  wire perr = ^dec_code;
  wire [PB-1:0] fix_chk = chk_of(dec_data);

  assign enc_code = {^{enc_chk, enc_data}, enc_chk, enc_data};
  assign dec_sbe = perr;
  assign dec_dbe = !perr && (syn != '0);
  assign dec_data = perr ? fix_of(raw, syn) : raw;
  // Fully re-encoded copy, used to scrub the array
  assign dec_fix = {^{fix_chk, dec_data}, fix_chk, dec_data};

endmodule

// ==========================================
// Shared second-level cache with ECC
module l2c_cache
  import l2c_pkg::*;
#(
  parameter int ADDR_W = L2C_ADDR_W,
  parameter int CACHE_KB = L2C_KB
)(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus address phase
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic req_l1_cacheable,
  input wire logic request_allocate_flag,
  input wire logic req_excl_owned,
  // Bus data phase (snooped)
  input wire logic dat_valid,
  input wire logic dat_write,
  input wire logic [ADDR_W-1:0] dat_addr,
  input wire logic [L2C_LINE_W-1:0] dat_line,
  input wire logic dat_err,
  // Read answer to requester
  output logic rsp_valid,
  output logic [L2C_LINE_W-1:0] rsp_line,
  output logic rsp_tag_err,
  output logic rsp_data_err,
  // Victim write-back to memory
  output logic wb_valid,
  output logic [ADDR_W-1:0] wb_addr,
  output logic [L2C_LINE_W-1:0] wb_line,
  // Management invalidate
  input wire logic mgmt_inval,
  input wire logic [l2c_log2(CACHE_KB * 8)-1:0] mgmt_index,
  input wire logic [L2C_WAY_W-1:0] mgmt_way,
  // Error tag capture
  output logic [ADDR_W-l2c_log2(CACHE_KB * 8)-L2C_OFF_W-1:0]
    last_error_tag_capture
);

  // ==========================================
  // Geometry: 1 KB = 8 sets of 4 x 32 bytes
  localparam int IDX_W = l2c_log2(CACHE_KB * 8);
  localparam int SETS = 1 << IDX_W;
  localparam int TAG_W = ADDR_W - IDX_W - L2C_OFF_W;
  localparam int TREC_W = TAG_W + L2C_TR_TAG;
  localparam int TCW = TREC_W + l2c_pbits(TREC_W) + 1;
  localparam int DCW = L2C_LINE_W + l2c_pbits(L2C_LINE_W) + 1;

  // ==========================================
  // Storage; not reset, software must sweep it first
  logic [TCW-1:0] tag_mem [L2C_WAYS][SETS];
  logic [DCW-1:0] dat_mem [L2C_WAYS][SETS];

  // Replacement and cleanup state
  logic [15:0] lfsr_ff; // Random way source
  logic cl_valid_ff; // Scrub queued
  logic [IDX_W-1:0] cl_idx_ff;
  logic [L2C_WAY_W-1:0] cl_way_ff;
  logic [TCW-1:0] cl_tcode_ff;
  logic [DCW-1:0] cl_dcode_ff;

  // Output registers
  logic rsp_valid_ff;
  logic [L2C_LINE_W-1:0] rsp_line_ff;
  logic rsp_tag_err_ff;
  logic rsp_data_err_ff;
  logic wb_valid_ff;
  logic [ADDR_W-1:0] wb_addr_ff;
  logic [L2C_LINE_W-1:0] wb_line_ff;
  logic [TAG_W-1:0] err_tag_ff;

  // ==========================================
  // Address phase lookup
  // Agent identity is never an input, so all agents look alike
  wire [IDX_W-1:0] rq_idx = req_addr[L2C_OFF_W +: IDX_W];
  wire [TAG_W-1:0] rq_tag = req_addr[ADDR_W-1 -: TAG_W];
  wire rq_look = req_valid & req_l1_cacheable;

  logic [TREC_W-1:0] rq_rec [L2C_WAYS]; // Corrected records
  logic [TCW-1:0] rq_tfix [L2C_WAYS];
  logic [TCW-1:0] rq_tenc [L2C_WAYS];
  logic [L2C_WAYS-1:0] rq_tsbe;
  logic [L2C_WAYS-1:0] rq_tdbe;
  logic [L2C_WAYS-1:0] rq_hitv;
  logic [TREC_W-1:0] alloc_rec; // Reserved line record

  // ==========================================
  // Data phase lookup
  wire [IDX_W-1:0] dp_idx = dat_addr[L2C_OFF_W +: IDX_W];
  wire [TAG_W-1:0] dp_tag = dat_addr[ADDR_W-1 -: TAG_W];

  logic [TREC_W-1:0] dp_rec [L2C_WAYS];
  logic [TCW-1:0] dp_tenc [L2C_WAYS];
  logic [L2C_WAYS-1:0] dp_hitv;
  logic [TREC_W-1:0] dupd_rec; // Record after data lands

  // Per-way tag decoders for both phases
  for (genvar w = 0; w < L2C_WAYS; w++)
  begin : g_way
    // All four ways are compared at one index
    l2c_secded #(.DW(TREC_W)) u_rq_tag (
      .enc_data(alloc_rec),
      .enc_code(rq_tenc[w]),
      .dec_code(tag_mem[w][rq_idx]),
      .dec_data(rq_rec[w]),
      .dec_fix(rq_tfix[w]),
      .dec_sbe(rq_tsbe[w]),
      .dec_dbe(rq_tdbe[w])
    );
    l2c_secded #(.DW(TREC_W)) u_dp_tag (
      .enc_data(dupd_rec),
      .enc_code(dp_tenc[w]),
      .dec_code(tag_mem[w][dp_idx]),
      .dec_data(dp_rec[w]),
      .dec_fix(),
      .dec_sbe(),
      .dec_dbe()
    );
    assign rq_hitv[w] = rq_rec[w][L2C_TR_VALID] &&
                        (rq_rec[w][TREC_W-1 -: TAG_W] == rq_tag);
    assign dp_hitv[w] = dp_rec[w][L2C_TR_VALID] &&
                        (dp_rec[w][TREC_W-1 -: TAG_W] == dp_tag);
  end

  // Hit way encoders; lowest way wins if init was skipped
  logic [L2C_WAY_W-1:0] rq_way;
  logic [L2C_WAY_W-1:0] dp_way;
  always_comb
  begin
    rq_way = '0;
    dp_way = '0;
    for (int w = L2C_WAYS - 1; w >= 0; w--)
    begin
      if (rq_hitv[w]) rq_way = L2C_WAY_W'(w);
      if (dp_hitv[w]) dp_way = L2C_WAY_W'(w);
    end
  end

  wire rq_hit = |rq_hitv;
  wire rq_tunc = |rq_tdbe; // Any bad tag makes the hit unknown
  wire dp_hit = |dp_hitv;

  // ==========================================
  // Data decode of hit way and of victim way
  logic [L2C_LINE_W-1:0] rq_line;
  logic [DCW-1:0] rq_dfix;
  logic [DCW-1:0] dp_denc;
  logic rq_dsbe;
  logic rq_ddbe;
  logic [L2C_LINE_W-1:0] vic_line;

  l2c_secded #(.DW(L2C_LINE_W)) u_rq_dat (
    .enc_data(dat_line),
    .enc_code(dp_denc),
    .dec_code(dat_mem[rq_way][rq_idx]),
    .dec_data(rq_line),
    .dec_fix(rq_dfix),
    .dec_sbe(rq_dsbe),
    .dec_dbe(rq_ddbe)
  );

  // Victim way comes from the free-running LFSR
  wire [L2C_WAY_W-1:0] vic_way = lfsr_ff[L2C_WAY_W-1:0];
  wire [TREC_W-1:0] vic_rec = rq_rec[vic_way];

  l2c_secded #(.DW(L2C_LINE_W)) u_vic_dat (
    .enc_data('0),
    .enc_code(),
    .dec_code(dat_mem[vic_way][rq_idx]),
    .dec_data(vic_line),
    .dec_fix(),
    .dec_sbe(),
    .dec_dbe()
  );

  // ==========================================
  // Address phase decisions
  // Answer on read hit, or junk when tag is unreadable
  wire rq_supply = rq_look & ~req_write & ~req_excl_owned &
                   (rq_hit | rq_tunc);
  // Allocate only on a clean miss with the flag set
  wire rq_alloc = rq_look & ~rq_hit & ~rq_tunc &
                  request_allocate_flag;
  wire rq_wb = rq_alloc & vic_rec[L2C_TR_VALID] &
               vic_rec[L2C_TR_DIRTY];
  wire rq_hsbe = rq_tsbe[rq_way] | rq_dsbe;
  wire rq_ecc = rq_look & (rq_tunc |
                (rq_hit & (rq_hsbe | rq_ddbe)));
  wire rq_clean = rq_look & rq_hit & ~rq_tunc & rq_hsbe;

  // Reserved line waits for its data phase
  assign alloc_rec = {rq_tag, 1'b1, 1'b0, 1'b1};

  // ==========================================
  // Data phase decisions
  // Writes land on any hit; fills only on a reserved line
  wire dp_take = dat_valid & dp_hit &
                 (dat_write | dp_rec[dp_way][L2C_TR_PEND]);
  assign dupd_rec = {dp_tag, 1'b0,
                     dat_write | dp_rec[dp_way][L2C_TR_DIRTY], 1'b1};
  // Poisoned data keeps a double error for later readers
  wire [DCW-1:0] dp_dcode = dat_err ?
       (dp_denc ^ {{(DCW - 2){1'b0}}, L2C_POISON}) : dp_denc;

  // ==========================================
  // Cleanup arbitration
  // Any write to the index drops the scrub, so the
  // error may show once more; cheaper than merging
  wire cl_hit_idx = (rq_alloc & (rq_idx == cl_idx_ff)) |
                    (dp_take & (dp_idx == cl_idx_ff)) |
                    (mgmt_inval & (mgmt_index == cl_idx_ff));
  wire cl_go = cl_valid_ff & ~cl_hit_idx;
  // A line rewritten in the hit cycle must not get its stale copy back
  wire cl_stale = (dp_take & (dp_idx == rq_idx)) |
                  (mgmt_inval & (mgmt_index == rq_idx));

  // ==========================================
  // Array writes; all in the same cycle, no stall
  always_ff @(posedge sys_clk)
  begin
    // Scrub corrected copy back
    if (cl_go)
    begin
      tag_mem[cl_way_ff][cl_idx_ff] <= cl_tcode_ff;
      dat_mem[cl_way_ff][cl_idx_ff] <= cl_dcode_ff;
    end
    // Reserve the victim way
    if (rq_alloc)
    begin
      tag_mem[vic_way][rq_idx] <= rq_tenc[0];
    end
    // Whole line from the data phase
    if (dp_take)
    begin
      tag_mem[dp_way][dp_idx] <= dp_tenc[0];
      dat_mem[dp_way][dp_idx] <= dp_dcode;
    end
    // Zero codeword is a valid code for an invalid line
    if (mgmt_inval)
    begin
      tag_mem[mgmt_way][mgmt_index] <= '0;
      dat_mem[mgmt_way][mgmt_index] <= '0;
    end
  end

  // ==========================================
  // Replacement LFSR, steps every cycle
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      lfsr_ff <= L2C_LFSR_SEED;
    else
      lfsr_ff <= {lfsr_ff[14:0], ^(lfsr_ff & L2C_LFSR_TAPS)};
  end

  // ==========================================
  // Cleanup queue, one entry; newest hit replaces it
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cl_valid_ff <= 1'b0;
    else
      cl_valid_ff <= rq_clean & ~cl_stale;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rq_clean)
    begin
      cl_idx_ff <= rq_idx;
      cl_way_ff <= rq_way;
      cl_tcode_ff <= rq_tfix[rq_way];
      cl_dcode_ff <= rq_dfix;
    end
  end

  // ==========================================
  // Read answer, one cycle after the request
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rsp_valid_ff <= 1'b0;
      rsp_line_ff <= '0;
      rsp_tag_err_ff <= 1'b0;
      rsp_data_err_ff <= 1'b0;
    end
    else
    begin
      rsp_valid_ff <= rq_supply;
      if (rq_supply)
      begin
        rsp_line_ff <= rq_line;
        rsp_tag_err_ff <= rq_tunc;
        rsp_data_err_ff <= rq_ddbe & ~rq_tunc;
      end
    end
  end

  // ==========================================
  // Dirty victim leaves as the line is reserved
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wb_valid_ff <= 1'b0;
      wb_addr_ff <= '0;
      wb_line_ff <= '0;
    end
    else
    begin
      wb_valid_ff <= rq_wb;
      if (rq_wb)
      begin
        wb_addr_ff <= {vic_rec[TREC_W-1 -: TAG_W], rq_idx,
                       {L2C_OFF_W{1'b0}}};
        wb_line_ff <= vic_line;
      end
    end
  end

  // ==========================================
  // Error tag capture; latest error overwrites
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      err_tag_ff <= '0;
    else if (rq_ecc)
      err_tag_ff <= rq_tag;
  end

  // ==========================================
  // Outputs
  assign rsp_valid = rsp_valid_ff;
  assign rsp_line = rsp_line_ff;
  assign rsp_tag_err = rsp_tag_err_ff;
  assign rsp_data_err = rsp_data_err_ff;
  assign wb_valid = wb_valid_ff;
  assign wb_addr = wb_addr_ff;
  assign wb_line = wb_line_ff;
  assign last_error_tag_capture = err_tag_ff;

endmodule

// ### l2c_cache_asserts.sv
`timescale 1ns/100ps

// ==========================================
// Port checker for the shared cache
module l2c_cache_asserts
  import l2c_pkg::*;
#(
  parameter int ADDR_W = L2C_ADDR_W,
  parameter int CACHE_KB = L2C_KB
)(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Address phase
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic req_l1_cacheable,
  input wire logic request_allocate_flag,
  input wire logic req_excl_owned,
  // Answers
  input wire logic rsp_valid,
  input wire logic [L2C_LINE_W-1:0] rsp_line,
  input wire logic wb_valid,
  input wire logic [ADDR_W-1:0] wb_addr,
  input wire logic [ADDR_W-l2c_log2(CACHE_KB * 8)-L2C_OFF_W-1:0] last_error_tag_capture
);
  // Tag width follows the configured size
  localparam int TW = ADDR_W - l2c_log2(CACHE_KB * 8) - L2C_OFF_W;
  // A request the cache must look up
  wire looked = req_valid && req_l1_cacheable;

  // ==========================================
  // Properties
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  chk_bypass_silent: assert property (!looked |=> !rsp_valid)
    else $error("answer without a looked-up request");
  chk_write_silent: assert property (looked && req_write |=> !rsp_valid)
    else $error("answer to a write request");
  chk_excl_silent: assert property (looked && req_excl_owned |=> !rsp_valid)
    else $error("answer to an owned block");
  chk_wb_cause: assert property (wb_valid |-> $past(looked && request_allocate_flag))
    else $error("write-back without allocating request");
  chk_wb_aligned: assert property (wb_valid |-> wb_addr[4:0] == 5'h00)
    else $error("write-back not line aligned");
  chk_etag_stable: assert property (!$past(looked) |-> $stable(last_error_tag_capture))
    else $error("error tag moved without a request");
  chk_etag_value: assert property ($changed(last_error_tag_capture) |->
    last_error_tag_capture == $past(req_addr[ADDR_W-1 -: TW]))
    else $error("error tag is not the request tag");
  chk_rsp_hold: assert property (!rsp_valid |-> $stable(rsp_line))
    else $error("read line changed between answers");

  // Main scenarios reached
  cover property (rsp_valid);
  cover property (wb_valid);
  cover property ($changed(last_error_tag_capture));
endmodule

bind l2c_cache l2c_cache_asserts #(.ADDR_W(ADDR_W), .CACHE_KB(CACHE_KB)) l2c_cache_asserts_i (
  .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
  .req_addr(req_addr), .req_l1_cacheable(req_l1_cacheable),
  .request_allocate_flag(request_allocate_flag), .req_excl_owned(req_excl_owned),
  .rsp_valid(rsp_valid), .rsp_line(rsp_line), .wb_valid(wb_valid), .wb_addr(wb_addr),
  .last_error_tag_capture(last_error_tag_capture));

// ### l2c_mem_model.sv
`timescale 1ns/100ps

// ==========================================
// Memory controller and bus data phase model
module l2c_mem_model
  import l2c_pkg::*;
#(
  parameter int ADDR_W = L2C_ADDR_W
)(
  // Clock
  input wire logic sys_clk,
  // Victim write-back from the cache
  input wire logic wb_valid,
  input wire logic [ADDR_W-1:0] wb_addr,
  input wire logic [L2C_LINE_W-1:0] wb_line,
  // Data phase on the bus
  output logic dat_valid = 1'b0,
  output logic dat_write = 1'b0,
  output logic [ADDR_W-1:0] dat_addr = '0,
  output logic [L2C_LINE_W-1:0] dat_line = '0,
  output logic dat_err = 1'b0
);
  // Sparse store; lines never written read a pattern
  logic [L2C_LINE_W-1:0] mem [logic [ADDR_W-1:0]];

  // Default content, unique per line address bits [31:0]
  function automatic logic [L2C_LINE_W-1:0] pat(input logic [ADDR_W-1:0] a);
    return {8{a[31:0] ^ 32'h5A5A0000}};
  endfunction

  // Absorb whole victim lines
  always @(posedge sys_clk)
    if (wb_valid)
      mem[wb_addr] = wb_line;

  // One line per strobe: requester data or a memory fill
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [L2C_LINE_W-1:0] d, input logic e);
    @(negedge sys_clk);
    dat_valid = 1'b1;
    dat_write = w;
    dat_addr = a;
    dat_line = w ? d : (mem.exists(a) ? mem[a] : pat(a));
    dat_err = e;
    @(negedge sys_clk);
    dat_valid = 1'b0;
    // Released bus must not keep showing the last line
    dat_line = ~dat_line;
    dat_addr = ~dat_addr;
    dat_err = 1'b0;
  endtask
endmodule

// ### test_l2c_cache.sv
`timescale 1ns/100ps

// ==========================================
// Self-checking bench for the shared cache
module test_l2c_cache;
  import l2c_pkg::*;
  // 128 KB keeps the init sweep short
  localparam int KB = 128;
  localparam int TW = L2C_ADDR_W - 15;
  // Clock, reset, address phase, management
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_l1_cacheable = 1'b0;
  logic request_allocate_flag = 1'b0;
  logic req_excl_owned = 1'b0;
  logic [L2C_ADDR_W-1:0] req_addr = '0;
  logic mgmt_inval = 1'b0;
  logic [9:0] mgmt_index = '0;
  logic [1:0] mgmt_way = '0;
  // Data phase and answers
  logic dat_valid, dat_write, dat_err, rsp_valid, rsp_tag_err, rsp_data_err, wb_valid;
  logic [L2C_ADDR_W-1:0] dat_addr, wb_addr, wa;
  logic [L2C_LINE_W-1:0] dat_line, rsp_line, wb_line, rl, wl;
  logic [TW-1:0] last_error_tag_capture, et;
  // Answer sampled after the last request
  logic rv, de, te, wv;
  int error_cnt = 0;
  int tests_run = 0;

  // ==========================================
  // Design, memory side and clock
  l2c_cache #(.CACHE_KB(KB)) l2c_cache_i (
    .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_l1_cacheable(req_l1_cacheable),
    .request_allocate_flag(request_allocate_flag), .req_excl_owned(req_excl_owned),
    .dat_valid(dat_valid), .dat_write(dat_write), .dat_addr(dat_addr), .dat_line(dat_line),
    .dat_err(dat_err), .rsp_valid(rsp_valid), .rsp_line(rsp_line), .rsp_tag_err(rsp_tag_err),
    .rsp_data_err(rsp_data_err), .wb_valid(wb_valid), .wb_addr(wb_addr), .wb_line(wb_line),
    .mgmt_inval(mgmt_inval), .mgmt_index(mgmt_index), .mgmt_way(mgmt_way),
    .last_error_tag_capture(last_error_tag_capture));
  l2c_mem_model l2c_mem_model_i (
    .sys_clk(sys_clk), .wb_valid(wb_valid), .wb_addr(wb_addr), .wb_line(wb_line),
    .dat_valid(dat_valid), .dat_write(dat_write), .dat_addr(dat_addr), .dat_line(dat_line),
    .dat_err(dat_err));
  always #5 sys_clk = ~sys_clk;

  // ==========================================
  // Helpers
  function automatic logic [L2C_ADDR_W-1:0] mk(input int t, input int i);
    return {t[TW-1:0], i[9:0], 5'h00};
  endfunction

  task automatic chk_bit(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g);
    end
  endtask

  task automatic chk_line(input string n, input logic [L2C_LINE_W-1:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g);
    end
  endtask

  task automatic chk_tag(input string n, input logic [TW-1:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Drive the address phase fields together
  task automatic put(input logic w, input logic [L2C_ADDR_W-1:0] a, input logic c, f, x);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_l1_cacheable = c;
    request_allocate_flag = f;
    req_excl_owned = x;
  endtask

  // One request; the answer is registered at the taking edge
  task automatic req(input logic w, input logic [L2C_ADDR_W-1:0] a, input logic c, f, x);
    @(negedge sys_clk);
    put(w, a, c, f, x);
    @(negedge sys_clk);
    req_valid = 1'b0;
    req_addr = ~a;
    rv = rsp_valid;
    rl = rsp_line;
    de = rsp_data_err;
    te = rsp_tag_err;
    et = last_error_tag_capture;
    wv = wb_valid;
    wl = wb_line;
    wa = wb_addr;
  endtask

  // One management invalidate per cycle
  task automatic inval(input int base, input int n);
    for (int i = base; i < base + n; i++)
    begin
      @(negedge sys_clk);
      mgmt_inval = 1'b1;
      mgmt_index = i[11:2];
      mgmt_way = i[1:0];
    end
    @(negedge sys_clk);
    mgmt_inval = 1'b0;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_read();
    req(0, mk(1, 3), 1, 0, 0);
    chk_bit("empty", 1'b0, rv);
    req(0, mk(1, 3), 0, 1, 0);
    chk_bit("bypass", 1'b0, rv);
    l2c_mem_model_i.xfer(0, mk(1, 3), '0, 0);
    req(0, mk(1, 3), 1, 0, 0);
    chk_bit("no_alloc", 1'b0, rv);
    req(0, mk(1, 3), 1, 1, 0);
    chk_bit("miss", 1'b0, rv);
    l2c_mem_model_i.xfer(0, mk(1, 3), '0, 0);
    req(0, mk(1, 3), 1, 0, 0);
    chk_bit("hit", 1'b1, rv);
    chk_line("fill", l2c_mem_model_i.pat(mk(1, 3)), rl);
    chk_bit("hit_data_err", 1'b0, de);
    chk_bit("hit_tag_err", 1'b0, te);
    req(0, mk(1, 3), 1, 1, 1);
    chk_bit("owned", 1'b0, rv);
    req(0, mk(1, 3) ^ 40'h4000, 1, 0, 0);
    chk_bit("index", 1'b0, rv);
  endtask

  // Back to back reads of one line
  task automatic t_pipe(input logic [L2C_ADDR_W-1:0] a, input logic [L2C_LINE_W-1:0] d);
    @(negedge sys_clk);
    put(0, a, 1, 0, 0);
    @(negedge sys_clk);
    chk_bit("pipe_a", 1'b1, rsp_valid);
    @(negedge sys_clk);
    req_valid = 1'b0;
    chk_bit("pipe_b", 1'b1, rsp_valid);
    chk_line("pipe_line", d, rsp_line);
  endtask

  task automatic t_write();
    req(1, mk(7, 5), 1, 1, 0);
    chk_bit("wr_quiet", 1'b0, rv);
    l2c_mem_model_i.xfer(1, mk(7, 5), {8{32'h1234ABCD}}, 0);
    t_pipe(mk(7, 5), {8{32'h1234ABCD}});
    req(1, mk(7, 5), 1, 0, 0);
    l2c_mem_model_i.xfer(1, mk(7, 5), 256'h5, 0);
    req(0, mk(7, 5) | 40'h1F, 1, 0, 0);
    chk_line("wr_hit", 256'h5, rl);
  endtask

  task automatic t_poison();
    req(1, mk(9, 6), 1, 1, 0);
    l2c_mem_model_i.xfer(1, mk(9, 6), '1, 1);
    req(0, mk(9, 6), 1, 0, 0);
    chk_bit("bad_resp", 1'b1, rv);
    chk_bit("data_err", 1'b1, de);
    chk_bit("bad_tag_flag", 1'b0, te);
    chk_tag("err_tag", TW'(9), et);
    inval(24, 4);
    req(0, mk(9, 6), 1, 0, 0);
    chk_bit("cleared", 1'b0, rv);
  endtask

  // Ten allocations into one set force at least six evictions
  task automatic t_evict();
    int n;
    n = 0;
    for (int k = 0; k < 10; k++)
    begin
      req(1, mk(100 + k, 8), 1, 1, 0);
      if (wv === 1'b1)
      begin
        n++;
        chk_line("wb_line", ~l2c_mem_model_i.pat(wa), wl);
        chk_line("wb_index", 10'h008, wa[14:5]);
      end
      l2c_mem_model_i.xfer(1, mk(100 + k, 8), ~l2c_mem_model_i.pat(mk(100 + k, 8)), 0);
    end
    chk_bit("wb_count", 1'b1, n >= 6);
    req(0, mk(109, 8), 1, 0, 0);
    chk_line("newest", ~l2c_mem_model_i.pat(mk(109, 8)), rl);
  endtask

  // ==========================================
  // Main sequence and hang guard
  initial
  begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    inval(0, 4096);
    t_read();
    t_write();
    t_poison();
    t_evict();
    end_sim();
  end

  initial
  begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    end_sim();
  end
endmodule
